/* logic/pmc_ctrl.sv */
// Purpose: Power-mode and system clock controller
// Assumes: Mode requests come from processor software as one-cycle pulses
// Notes: Domain enables are levels; a clock or power gate sits outside
`timescale 1ns/1ps
// Summary of operation
// - Active mode clocks processor and every enabled peripheral.
// - Idle gates processor core and memory clocks, peripherals stay clocked.
// - Any interrupt while idle returns to active.
// - Standby powers only the always-on and sensor domains.
// - Standby exits only on pin, real-time-clock or sensor processor event.
// - Standby keeps retained peripheral state; processor resumes where it stopped.
// - All general pins held latched throughout standby.
// - Shutdown switches everything off; pins keep pre-shutdown values.
// - Enabled shutdown pin level change wakes device as a reset.
// - Last reset cause distinguishes shutdown wake, reset pin, power-on.
// - Across shutdown only latched pins and nonvolatile memory persist.
// - Main clock is 48 MHz from fast RC or fast crystal.
// - Radio allowed only with main clock from fast crystal.
// - Medium clock is 2 MHz from medium RC, feeds sensor and power logic.
// - Low-frequency clock from slow RC, slow crystal or a pin.
// - Low-frequency clock may go out on a pin for RC or crystal.
// - Low-frequency clock drives real-time clock and radio timer resync.
// - Sensor processor runs its peripherals alone; processor may also control them.
module pmc_ctrl
  import pmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_event,
  input wire logic reset_pin_event,
  input wire logic mode_req_valid,
  input wire logic [1:0] mode_req,
  input wire logic cpu_irq,
  input wire logic wake_pin_event,
  input wire logic rtc_event,
  input wire logic sensor_event,
  input wire logic [PMC_NUM_PINS-1:0] pin_out_live,
  input wire logic [PMC_NUM_PINS-1:0] pin_in,
  input wire logic [PMC_NUM_PINS-1:0] shutdown_wake_en,
  input wire logic main_clk_src_sel,
  input wire logic xtal_hf_ready,
  input wire logic [1:0] lf_clk_src_sel,
  input wire logic lf_clk_out_req,
  input wire logic radio_req,
  input wire logic sensor_owns_periph,
  input wire logic cpu_periph_req,
  output logic [2:0] power_mode,
  output logic cpu_clk_en,
  output logic mem_clk_en,
  output logic periph_clk_en,
  output logic main_domain_pwr,
  output logic always_on_domain_pwr,
  output logic sensor_pwr,
  output logic retain_en,
  output logic resume_ctx,
  output logic pin_hold,
  output logic [PMC_NUM_PINS-1:0] pin_out,
  output logic wake_reset,
  output logic [1:0] reset_cause,
  output logic main_system_clock_en,
  output logic main_clk_from_xtal,
  output logic medium_speed_clock_en,
  output logic low_frequency_clock_en,
  output logic [1:0] low_frequency_clock_src,
  output logic lf_clk_out_en,
  output logic rtc_clk_en,
  output logic radio_timer_resync,
  output logic radio_en,
  output logic periph_owner_cpu
);
  pmc_mode_e mode_q, mode_d;
  pmc_mode_e target_q, target_d;
  logic [4:0] settle_q, settle_d;
  logic [1:0] cause_q, cause_d;
  logic wake_rst_q, wake_rst_d;
  logic resume_q, resume_d;
  logic resync_q, resync_d;
  logic hold_q, hold_d;
  logic main_src_q, main_src_d;
  logic [1:0] lf_src_q, lf_src_d;
  logic pin_wake_hit;
  logic [PMC_NUM_PINS-1:0] pin_held;
  logic out_cpu_clk_d, out_mem_clk_d, out_periph_clk_d, out_main_pwr_d;
  logic out_sensor_pwr_d, out_retain_d, out_mf_d, out_lf_d, out_lfo_d;
  logic out_radio_d, out_owner_d, out_hf_d;
  logic out_cpu_clk_q, out_mem_clk_q, out_periph_clk_q, out_main_pwr_q;
  logic out_sensor_pwr_q, out_retain_q, out_mf_q, out_lf_q, out_lfo_q;
  logic out_radio_q, out_owner_q, out_hf_q, out_aon_q, out_aon_d;
  logic [PMC_NUM_PINS-1:0] pin_out_q;

  // Pin latch and shutdown wake detector
  pmc_pin_latch u_pin_latch (
    .clk(clk),
    .rst_n(rst_n),
    .hold(hold_q),
    .arm(mode_q == PMC_SHUTDOWN),
    .pin_out_live(pin_out_live),
    .pin_in(pin_in),
    .wake_pin_en(shutdown_wake_en),
    .pin_out_held(pin_held),
    .wake_hit(pin_wake_hit)
  );

  // Mode sequencer
  // Requests count only while active; elsewhere they drop with no sign
  always_comb begin
    mode_d = mode_q;
    target_d = target_q;
    settle_d = (settle_q != 5'h00) ? settle_q - 5'h01 : settle_q;
    wake_rst_d = 1'b0;
    resume_d = 1'b0;
    resync_d = 1'b0;
    hold_d = hold_q;
    case (mode_q)
      PMC_ACTIVE: begin
        hold_d = 1'b0;
        if (mode_req_valid) begin
          case (mode_req)
            PMC_REQ_IDLE: mode_d = PMC_IDLE;
            PMC_REQ_STANDBY: begin
              mode_d = PMC_STANDBY;
              hold_d = 1'b1;
              resync_d = 1'b1;
            end
            PMC_REQ_SHUTDOWN: begin
              mode_d = PMC_SHUTDOWN;
              hold_d = 1'b1;
            end
            // Code 0 is no request at all
            default: mode_d = PMC_ACTIVE;
          endcase
        end
      end
      PMC_IDLE: begin
        // Only an interrupt ends idle; requests are ignored here
        if (cpu_irq) begin
          mode_d = PMC_ACTIVE;
        end
      end
      PMC_STANDBY: begin
        hold_d = 1'b1;
        // An interrupt alone does not end standby
        if (wake_pin_event || rtc_event || sensor_event) begin
          mode_d = PMC_WAKING;
          target_d = PMC_ACTIVE;
          settle_d = PMC_SETTLE_INIT;
        end
      end
      PMC_WAKING: begin
        // Domains get the settle span before the processor is let go
        hold_d = 1'b1;
        if (settle_q == 5'h00) begin
          mode_d = target_q;
          hold_d = 1'b0;
          resume_d = 1'b1;
          resync_d = 1'b1;
        end
      end
      PMC_SHUTDOWN: begin
        // Only pin edges wake from here; it restarts as a reset
        if (pin_wake_hit) begin
          wake_rst_d = 1'b1;
          mode_d = PMC_ACTIVE;
          hold_d = 1'b0;
        end
      end
      default: mode_d = PMC_ACTIVE;
    endcase
  end

  // Reset cause: later events in same cycle override earlier ones
  always_comb begin
    cause_d = cause_q;
    if (wake_rst_q) begin
      cause_d = PMC_RC_SHUTDOWN_WAKE;
    end
    if (reset_pin_event) begin
      cause_d = PMC_RC_PIN;
    end
    if (por_event) begin
      cause_d = PMC_RC_POR;
    end
  end

  // Clock source selection applies only while fully active, not in idle
  always_comb begin
    main_src_d = main_src_q;
    lf_src_d = lf_src_q;
    if (mode_q == PMC_ACTIVE) begin
      // Crystal chosen only once it is ready, else stay on RC
      main_src_d = (main_clk_src_sel == PMC_HF_XTAL && xtal_hf_ready) ? PMC_HF_XTAL
                   : PMC_HF_RC;
      if (lf_clk_src_sel <= PMC_LF_PIN) begin
        lf_src_d = lf_clk_src_sel;
      end
    end
    // A shutdown wake restarts like a reset, so the old selection is dropped
    if (wake_rst_q) begin
      main_src_d = PMC_HF_RC;
      lf_src_d = PMC_LF_RC;
    end
  end

  // Domain and clock enables per mode
  always_comb begin
    out_cpu_clk_d = 1'b0;
    out_mem_clk_d = 1'b0;
    out_periph_clk_d = 1'b0;
    out_main_pwr_d = 1'b0;
    out_sensor_pwr_d = 1'b0;
    out_retain_d = 1'b0;
    out_hf_d = 1'b0;
    out_mf_d = 1'b0;
    out_lf_d = 1'b0;
    out_aon_d = 1'b0;
    case (mode_d)
      PMC_ACTIVE: begin
        out_cpu_clk_d = 1'b1;
        out_mem_clk_d = 1'b1;
        out_periph_clk_d = 1'b1;
        out_main_pwr_d = 1'b1;
        out_sensor_pwr_d = 1'b1;
        out_hf_d = 1'b1;
        out_mf_d = 1'b1;
        out_lf_d = 1'b1;
        out_aon_d = 1'b1;
      end
      PMC_IDLE: begin
        out_periph_clk_d = 1'b1;
        out_main_pwr_d = 1'b1;
        out_sensor_pwr_d = 1'b1;
        out_hf_d = 1'b1;
        out_mf_d = 1'b1;
        out_lf_d = 1'b1;
        out_aon_d = 1'b1;
      end
      PMC_STANDBY, PMC_WAKING: begin
        out_aon_d = 1'b1;
        out_sensor_pwr_d = 1'b1;
        out_retain_d = 1'b1;
        out_mf_d = 1'b1;
        out_lf_d = 1'b1;
      end
      default: begin
        // Shutdown: nothing on, retention off too
        out_aon_d = 1'b0;
      end
    endcase
    // Clock out only from RC or crystal, never a pin-sourced clock
    out_lfo_d = lf_clk_out_req && out_lf_d && (lf_src_d != PMC_LF_PIN);
    // The RC is too coarse to time the radio, so the crystal is required
    out_radio_d = radio_req && out_hf_d && (main_src_d == PMC_HF_XTAL);
    // Sensor runs its peripherals alone; the processor may take them
    out_owner_d = cpu_periph_req || !sensor_owns_periph;
  end

  // State registers
  // The cause register is not reset by a shutdown wake; it records the wake instead
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= PMC_ACTIVE;
      target_q <= PMC_ACTIVE;
      settle_q <= 5'h00;
      cause_q <= PMC_RC_INIT;
      wake_rst_q <= 1'b0;
      resume_q <= 1'b0;
      resync_q <= 1'b0;
      hold_q <= 1'b0;
      main_src_q <= PMC_HF_RC;
      lf_src_q <= PMC_LF_RC;
    end else begin
      mode_q <= mode_d;
      target_q <= target_d;
      settle_q <= settle_d;
      cause_q <= cause_d;
      wake_rst_q <= wake_rst_d;
      resume_q <= resume_d;
      resync_q <= resync_d;
      hold_q <= hold_d;
      main_src_q <= main_src_d;
      lf_src_q <= lf_src_d;
    end
  end

  // Output registers
  // Reset values are the active-mode ones, so nothing drops out after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_cpu_clk_q <= 1'b1;
      out_mem_clk_q <= 1'b1;
      out_periph_clk_q <= 1'b1;
      out_main_pwr_q <= 1'b1;
      out_sensor_pwr_q <= 1'b1;
      out_retain_q <= 1'b0;
      out_hf_q <= 1'b1;
      out_mf_q <= 1'b1;
      out_lf_q <= 1'b1;
      out_aon_q <= 1'b1;
      out_lfo_q <= 1'b0;
      out_radio_q <= 1'b0;
      out_owner_q <= 1'b1;
      pin_out_q <= '0;
    end else begin
      out_cpu_clk_q <= out_cpu_clk_d;
      out_mem_clk_q <= out_mem_clk_d;
      out_periph_clk_q <= out_periph_clk_d;
      out_main_pwr_q <= out_main_pwr_d;
      out_sensor_pwr_q <= out_sensor_pwr_d;
      out_retain_q <= out_retain_d;
      out_hf_q <= out_hf_d;
      out_mf_q <= out_mf_d;
      out_lf_q <= out_lf_d;
      out_aon_q <= out_aon_d;
      out_lfo_q <= out_lfo_d;
      out_radio_q <= out_radio_d;
      out_owner_q <= out_owner_d;
      pin_out_q <= pin_held;
    end
  end

  // Ports come straight from the registers above
  assign power_mode = mode_q;
  assign cpu_clk_en = out_cpu_clk_q;
  assign mem_clk_en = out_mem_clk_q;
  assign periph_clk_en = out_periph_clk_q;
  assign main_domain_pwr = out_main_pwr_q;
  assign always_on_domain_pwr = out_aon_q;
  assign sensor_pwr = out_sensor_pwr_q;
  assign retain_en = out_retain_q;
  assign resume_ctx = resume_q;
  assign pin_hold = hold_q;
  assign pin_out = pin_out_q;
  assign wake_reset = wake_rst_q;
  assign reset_cause = cause_q;
  assign main_system_clock_en = out_hf_q;
  assign main_clk_from_xtal = main_src_q;
  assign medium_speed_clock_en = out_mf_q;
  assign low_frequency_clock_en = out_lf_q;
  assign low_frequency_clock_src = lf_src_q;
  assign lf_clk_out_en = out_lfo_q;
  assign rtc_clk_en = out_lf_q;
  assign radio_timer_resync = resync_q;
  assign radio_en = out_radio_q;
  assign periph_owner_cpu = out_owner_q;
endmodule

/* logic/pmc_pin_latch.sv */
// Purpose: Per-pin output latch and shutdown wake detector
// Assumes: Pin inputs synchronous to clk
// Notes: Latched value survives shutdown; only pin states are held
`timescale 1ns/1ps
module pmc_pin_latch
  import pmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic arm,
  input wire logic [PMC_NUM_PINS-1:0] pin_out_live,
  input wire logic [PMC_NUM_PINS-1:0] pin_in,
  input wire logic [PMC_NUM_PINS-1:0] wake_pin_en,
  output logic [PMC_NUM_PINS-1:0] pin_out_held,
  output logic wake_hit
);
  logic [PMC_NUM_PINS-1:0] held_q, held_d;
  logic [PMC_NUM_PINS-1:0] ref_q, ref_d;
  logic [PMC_NUM_PINS-1:0] hit;

  genvar i;
  generate
    for (i = 0; i < PMC_NUM_PINS; i++) begin : g_pin
      // Track live value until hold, then freeze
      always_comb begin
        held_d[i] = hold ? held_q[i] : pin_out_live[i];
        ref_d[i] = arm ? ref_q[i] : pin_in[i];
        hit[i] = arm && wake_pin_en[i] && (pin_in[i] != ref_q[i]);
      end
    end
  endgenerate

  assign pin_out_held = held_q;
  assign wake_hit = |hit;

  // Latch is not cleared by the wake reset itself: hold decides
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      held_q <= '0;
      ref_q <= '0;
    end else begin
      held_q <= held_d;
      ref_q <= ref_d;
    end
  end
endmodule

/* logic/pmc_pkg.sv */
// Purpose: Shared constants and types for the power-mode controller
// Assumes: Single 125 MHz clock, synchronous active-low reset
// Notes: Mode and clock-source encodings are local to this block
package pmc_pkg;
  localparam int unsigned PMC_NUM_PINS = 8;
  localparam int unsigned PMC_CLK_MHZ = 125;
  // Clock frequencies, main and medium in kHz, slow ones in Hz, as figures for the clock selection outputs
  localparam int unsigned PMC_MAIN_CLK_KHZ = 48000;
  localparam int unsigned PMC_MED_CLK_KHZ = 2000;
  localparam int unsigned PMC_LF_XTAL_HZ = 32768;
  localparam int unsigned PMC_LF_RC_HZ = 32800;
  // Settle time for power domains before a wake from standby completes
  localparam int unsigned PMC_SETTLE_NS = 200;
  localparam int unsigned PMC_SETTLE_CYC = (PMC_SETTLE_NS * PMC_CLK_MHZ + 999) / 1000;
  localparam logic [4:0] PMC_SETTLE_INIT = 5'(PMC_SETTLE_CYC);

  typedef enum logic [2:0] {
    PMC_ACTIVE   = 3'h0,
    PMC_IDLE     = 3'h1,
    PMC_STANDBY  = 3'h2,
    PMC_SHUTDOWN = 3'h3,
    PMC_WAKING   = 3'h4
  } pmc_mode_e;

  // Software request codes
  localparam logic [1:0] PMC_REQ_IDLE = 2'h1;
  localparam logic [1:0] PMC_REQ_STANDBY = 2'h2;
  localparam logic [1:0] PMC_REQ_SHUTDOWN = 2'h3;

  // Main clock sources
  localparam logic PMC_HF_RC = 1'b0;
  localparam logic PMC_HF_XTAL = 1'b1;
  // Low-frequency clock sources
  localparam logic [1:0] PMC_LF_RC = 2'h0;
  localparam logic [1:0] PMC_LF_XTAL = 2'h1;
  localparam logic [1:0] PMC_LF_PIN = 2'h2;

  // Reset cause codes
  localparam logic [1:0] PMC_RC_POR = 2'h0;
  localparam logic [1:0] PMC_RC_PIN = 2'h1;
  localparam logic [1:0] PMC_RC_SHUTDOWN_WAKE = 2'h2;
  localparam logic [1:0] PMC_RC_INIT = PMC_RC_POR;
endpackage

/* test/pmc_ctrl_assertions.sv */
// Purpose: Port-level timing checks for the power-mode controller
// Assumes: Single clock, synchronous active-low reset
// Notes: Waking span of 26 cycles follows the 25-cycle settle figure plus one
`timescale 1ns/1ps
module pmc_ctrl_chk
  import pmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_event,
  input wire logic reset_pin_event,
  input wire logic mode_req_valid,
  input wire logic [1:0] mode_req,
  input wire logic cpu_irq,
  input wire logic wake_pin_event,
  input wire logic rtc_event,
  input wire logic sensor_event,
  input wire logic [2:0] power_mode,
  input wire logic cpu_clk_en,
  input wire logic mem_clk_en,
  input wire logic periph_clk_en,
  input wire logic always_on_domain_pwr,
  input wire logic sensor_pwr,
  input wire logic resume_ctx,
  input wire logic pin_hold,
  input wire logic [PMC_NUM_PINS-1:0] pin_out,
  input wire logic wake_reset,
  input wire logic [1:0] reset_cause,
  input wire logic main_clk_from_xtal,
  input wire logic [1:0] low_frequency_clock_src,
  input wire logic lf_clk_out_en,
  input wire logic radio_en
);
  // One domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  req_take_a: assert property (
    power_mode == 3'h0 && mode_req_valid && mode_req != 2'h0
    |=> power_mode == {1'b0, $past(mode_req)}) else $error("mode request not taken");
  idle_gate_a: assert property (
    power_mode == 3'h1 |-> !cpu_clk_en && !mem_clk_en && periph_clk_en)
    else $error("idle clock gating wrong");
  idle_exit_a: assert property (
    power_mode == 3'h1 && cpu_irq |=> power_mode == 3'h0) else $error("idle not left");
  stby_hold_a: assert property (
    power_mode == 3'h2 |-> pin_hold && always_on_domain_pwr && !cpu_clk_en && !periph_clk_en)
    else $error("standby domains or pin hold wrong");
  stby_stay_a: assert property (
    power_mode == 3'h2 && !(wake_pin_event || rtc_event || sensor_event)
    |=> power_mode == 3'h2) else $error("standby left without wake");
  stby_wake_a: assert property (
    power_mode == 3'h2 ##1 power_mode == 3'h4
    |-> ##25 power_mode == 3'h4 ##1 (power_mode == 3'h0 && resume_ctx))
    else $error("standby resume timing wrong");
  shut_off_a: assert property (
    power_mode == 3'h3 |-> !always_on_domain_pwr && !sensor_pwr)
    else $error("shutdown left a domain on");
  shut_pins_a: assert property (
    power_mode == 3'h3 && $past(power_mode) == 3'h3 |-> $stable(pin_out))
    else $error("pins moved in shutdown");
  cause_wake_a: assert property (
    wake_reset && !por_event && !reset_pin_event |=> reset_cause == PMC_RC_SHUTDOWN_WAKE)
    else $error("wake cause not recorded");
  radio_xtal_a: assert property (
    radio_en |-> main_clk_from_xtal) else $error("radio without crystal");
  lf_out_a: assert property (
    lf_clk_out_en |-> low_frequency_clock_src != PMC_LF_PIN)
    else $error("pin clock driven out");
endmodule

bind pmc_ctrl pmc_ctrl_chk u_pmc_ctrl_chk (.*);

/* test/pmc_ctrl_tb.sv */
// Purpose: Self-checking bench for the power-mode controller
// Assumes: 125 MHz clock, inputs moved 1 ns after each rising edge
// Notes: Reset cause settles one cycle after the event or wake pulse that sets it
`timescale 1ns/1ps
module pmc_ctrl_tb
  import pmc_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, por_event = 1'b0, reset_pin_event = 1'b0;
  logic mode_req_valid = 1'b0, cpu_irq = 1'b0, main_clk_src_sel = 1'b0, xtal_hf_ready = 1'b0;
  logic lf_clk_out_req = 1'b0, radio_req = 1'b0, sensor_owns_periph = 1'b0;
  logic cpu_periph_req = 1'b0;
  logic [1:0] mode_req = 2'h0, lf_clk_src_sel = 2'h0;
  logic [PMC_NUM_PINS-1:0] pin_out_live = 8'h00, shutdown_wake_en = 8'h0F;
  logic [PMC_NUM_PINS-1:0] pin_in, pin_out;
  logic wake_pin_event, rtc_event, sensor_event;
  logic [2:0] power_mode;
  logic [1:0] reset_cause, low_frequency_clock_src;
  logic cpu_clk_en, mem_clk_en, periph_clk_en, main_domain_pwr, always_on_domain_pwr;
  logic sensor_pwr, retain_en, resume_ctx, pin_hold, wake_reset, main_system_clock_en;
  logic main_clk_from_xtal, medium_speed_clock_en, low_frequency_clock_en, lf_clk_out_en;
  logic rtc_clk_en, radio_timer_resync, radio_en, periph_owner_cpu;
  int errors = 0;
  int samples_checked = 0;

  pmc_ctrl u_pmc_ctrl (.*);
  pmc_wake_src u_pmc_wake_src (.*);

  // Free-running clock
  always #4 clk = ~clk;

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request pulse taken at the next edge
  task automatic req(input logic [1:0] c);
    mode_req_valid = 1'b1;
    mode_req = c;
    step(1);
    mode_req_valid = 1'b0;
  endtask

  task automatic complete_run();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic t_reset();
    chk("power_mode", 8'h00, 8'(power_mode));
    chk("cpu_clk_en", 8'h01, 8'(cpu_clk_en));
    chk("reset_cause", 8'(PMC_RC_POR), 8'(reset_cause));
    chk("medium_clk", 8'h01, 8'(medium_speed_clock_en));
  endtask

  // Idle entry, refused request while idle, interrupt exit, ignored code
  task automatic t_idle();
    req(PMC_REQ_IDLE);
    chk("power_mode", 8'h01, 8'(power_mode));
    chk("clk_gates", 8'h01, 8'({cpu_clk_en, mem_clk_en, periph_clk_en}));
    step(1);
    req(PMC_REQ_SHUTDOWN);
    chk("power_mode", 8'h01, 8'(power_mode));
    cpu_irq = 1'b1;
    step(1);
    cpu_irq = 1'b0;
    chk("power_mode", 8'h00, 8'(power_mode));
    req(2'h0);
    chk("power_mode", 8'h00, 8'(power_mode));
  endtask

  // Standby held through an interrupt, left by one wake source
  task automatic t_standby(input int src, input int dly);
    int n;
    pin_out_live = 8'h3C;
    step(3);
    req(PMC_REQ_STANDBY);
    chk("power_mode", 8'h02, 8'(power_mode));
    chk("retain_en", 8'h01, 8'(retain_en));
    chk("stby_resync", 8'h01, 8'(radio_timer_resync));
    chk("stby_main", 8'h00, 8'({main_domain_pwr, main_system_clock_en}));
    pin_out_live = 8'hC3;
    cpu_irq = 1'b1;
    step(4);
    cpu_irq = 1'b0;
    chk("power_mode", 8'h02, 8'(power_mode));
    chk("pin_out", 8'h3C, pin_out);
    u_pmc_wake_src.fire(src, dly);
    chk("power_mode", 8'h04, 8'(power_mode));
    n = 0;
    while (power_mode !== 3'h0 && n < 40) begin
      step(1);
      n++;
    end
    chk("wake_cycles", 8'(PMC_SETTLE_CYC + 1), 8'(n));
    chk("resume_ctx", 8'h01, 8'(resume_ctx));
    chk("wake_resync", 8'h01, 8'(radio_timer_resync));
    step(3);
    chk("pin_out", 8'hC3, pin_out);
  endtask

  // Shutdown: masked pin ignored, enabled pin wakes, causes recorded
  task automatic t_shutdown();
    int n;
    pin_out_live = 8'h5A;
    step(3);
    req(PMC_REQ_SHUTDOWN);
    chk("power_mode", 8'h03, 8'(power_mode));
    chk("aon_sensor", 8'h00, 8'({always_on_domain_pwr, sensor_pwr}));
    pin_out_live = 8'h00;
    u_pmc_wake_src.set_pins(8'h80);
    step(4);
    chk("power_mode", 8'h03, 8'(power_mode));
    chk("pin_out", 8'h5A, pin_out);
    u_pmc_wake_src.set_pins(8'h81);
    n = 0;
    while (power_mode !== 3'h0 && n < 4) begin
      step(1);
      n++;
    end
    chk("power_mode", 8'h00, 8'(power_mode));
    chk("wake_reset", 8'h01, 8'(wake_reset));
    step(1);
    chk("reset_cause", 8'(PMC_RC_SHUTDOWN_WAKE), 8'(reset_cause));
    reset_pin_event = 1'b1;
    step(1);
    reset_pin_event = 1'b0;
    step(1);
    chk("reset_cause", 8'(PMC_RC_PIN), 8'(reset_cause));
    por_event = 1'b1;
    step(1);
    por_event = 1'b0;
    step(1);
    chk("reset_cause", 8'(PMC_RC_POR), 8'(reset_cause));
    u_pmc_wake_src.set_pins(8'h00);
  endtask

  // Radio gating on crystal readiness, then every slow clock source
  task automatic t_clocks();
    main_clk_src_sel = PMC_HF_XTAL;
    radio_req = 1'b1;
    step(3);
    chk("radio_en", 8'h00, 8'(radio_en));
    xtal_hf_ready = 1'b1;
    step(3);
    chk("from_xtal", 8'h01, 8'(main_clk_from_xtal));
    chk("radio_en", 8'h01, 8'(radio_en));
    main_clk_src_sel = PMC_HF_RC;
    step(3);
    chk("radio_en", 8'h00, 8'(radio_en));
    radio_req = 1'b0;
    lf_clk_out_req = 1'b1;
    for (int s = 0; s < 3; s++) begin
      lf_clk_src_sel = 2'(s);
      step(3);
      chk("lf_src", 8'(s), 8'(low_frequency_clock_src));
      chk("lf_out", 8'(s != 2), 8'(lf_clk_out_en));
      chk("rtc_clk", 8'h01, 8'(rtc_clk_en));
    end
    lf_clk_src_sel = 2'h3;
    step(3);
    chk("lf_src_hold", 8'(PMC_LF_PIN), 8'(low_frequency_clock_src));
    sensor_owns_periph = 1'b1;
    step(2);
    chk("owner_cpu", 8'h00, 8'(periph_owner_cpu));
    cpu_periph_req = 1'b1;
    step(2);
    chk("owner_cpu", 8'h01, 8'(periph_owner_cpu));
  endtask

  // Main sequence after an 8-cycle reset
  initial begin
    step(8);
    rst_n = 1'b1;
    t_reset();
    t_idle();
    for (int k = 0; k < 3; k++)
      t_standby(k, k);
    t_shutdown();
    t_clocks();
    complete_run();
  end

  // Watchdog well beyond the roughly 170 cycles the run needs
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    $display("[ERR] watchdog expected done seen hang");
    complete_run();
  end
endmodule

/* test/pmc_wake_src.sv */
// Purpose: Behavioural model of the wake sources: pins, timer, sensor core
// Assumes: Driven just after a rising edge of clk
// Notes: Events are one-cycle pulses; a wait picks a prompt or slow answer
`timescale 1ns/1ps
module pmc_wake_src
  import pmc_pkg::*;
(
  input wire logic clk,
  output logic wake_pin_event,
  output logic rtc_event,
  output logic sensor_event,
  output logic [PMC_NUM_PINS-1:0] pin_in
);
  // Quiet sources and low pins at start
  initial begin
    wake_pin_event = 1'b0;
    rtc_event = 1'b0;
    sensor_event = 1'b0;
    pin_in = 8'h00;
  end

  // One wake pulse after dly cycles; 0 pin, 1 timer, 2 sensor
  task automatic fire(input int src, input int dly);
    repeat (dly) begin
      @(posedge clk);
      #1;
    end
    wake_pin_event = (src == 0);
    rtc_event = (src == 1);
    sensor_event = (src == 2);
    @(posedge clk);
    #1;
    wake_pin_event = 1'b0;
    rtc_event = 1'b0;
    sensor_event = 1'b0;
  endtask

  // Pin levels seen by the shutdown wake detector
  task automatic set_pins(input logic [PMC_NUM_PINS-1:0] v);
    pin_in = v;
  endtask
endmodule
